// >>> tsw_pkg.sv
// Shared constants and types for the time slot switch control block
package tsw_pkg;
  // Host address map
  localparam int ADDR_W = 6;
  localparam int REGION_BIT = 5;                      // High selects a channel location
  localparam logic [5:0] CTRL_BASE = 6'h00;           // Control register, 00-1F
  localparam logic [5:0] CHAN_BASE = 6'h20;           // Channel 0, up to 3F for channel 31
  // Control register fields
  localparam int SPLIT_BIT = 7;                       // split_access_bit
  localparam int PE_BIT = 6;                          // global_literal_output_bit
  localparam int UNUSED_BIT = 5;
  localparam int MS_HI = 4;                           // memory_choice_field msb
  localparam int MS_LO = 3;
  localparam int STA_HI = 2;                          // stream_number_field msb
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hdf;          // Bit 5 stores nothing
  // Memory choice codes
  localparam logic [1:0] MS_NONE = 2'h0;
  localparam logic [1:0] MS_DATA = 2'h1;
  localparam logic [1:0] MS_LOW = 2'h2;
  localparam logic [1:0] MS_HIGH = 2'h3;
  // High word fields, only three bits are stored
  localparam int HW_W = 3;
  localparam int HW_SRC = 2;                          // Source select
  localparam int HW_CCO = 1;                          // Control bitstream bit
  localparam int HW_OE = 0;                           // Output enable
  // Serial timing
  localparam int CLK_KHZ = 10000;                     // CLK rate in kHz
  localparam int BIT_KBPS = 2048;                     // Serial bit rate in kbit/s
  localparam int BITS_PER_FRAME = 256;
  localparam int ACC_W = 14;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_KBPS);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_RESET = 14'h0000;
  localparam logic [7:0] CNT_RESET = 8'h00;
  // Host access states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10,
    ST_HOLD = 2'b11
  } tsw_state_t;
endpackage

// >>> tsw_mem.sv
// Small 256-location memory with one write port and two registered read ports
`timescale 1ns/1ps
module tsw_mem #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port A
  input wire logic [7:0] ra_addr,
  output logic [W-1:0] ra_data,
  // Read port B
  input wire logic [7:0] rb_addr,
  output logic [W-1:0] rb_data
);
  logic [W-1:0] mem [0:255]; // Contents are undefined after power up

  // Storage, no reset so it maps onto RAM
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered reads, one cycle of latency on both ports
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ra_data <= '0;
      rb_data <= '0;
    end
    else
    begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end
endmodule

// >>> tsw_switch_ctrl.sv
// Host register window and per-channel output control of the slot switch
`timescale 1ns/1ps
module tsw_switch_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Host parallel port
  input wire logic [5:0] HOST_ADDR,
  input wire logic HOST_CS_N,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic HOST_READY,
  // Data memory fill from the receive framer
  input wire logic DM_WR_EN,
  input wire logic [7:0] DM_WR_ADDR,
  input wire logic [7:0] DM_WR_DATA,
  // Serial side
  input wire logic GLOBAL_OUTPUT_GATE,
  output logic [7:0] SERIAL_OUTPUT_STREAMS,
  output logic [7:0] SERIAL_OUTPUT_OE,
  output logic CONTROL_BITSTREAM_OUT
);
  logic [17:0] sync1_r; // First stage, read only by the second
  logic [17:0] sync2_r; // Settled pin levels
  logic [5:0] addr_s;
  logic [7:0] din_s;
  logic cs_n_s, rd_n_s, wr_n_s, gate_s;
  logic strobe; // Host cycle in progress
  logic [7:0] ctrl_r; // Control register
  tsw_pkg::tsw_state_t state_r;
  logic [7:0] host_rd_r; // Latched read data
  logic rd_cycle_r; // Current cycle is a read
  logic [7:0] mem_rd; // Memory read data offered to the host
  logic split, pe;
  logic [1:0] ms;
  logic [7:0] host_mem_addr; // Stream and channel
  logic low_we, high_we;
  logic [7:0] dm_a, low_a, dm_b, low_b;
  logic [2:0] high_a, high_b;
  logic [tsw_pkg::ACC_W-1:0] acc_r, acc_sum; // Fractional bit-rate divider and its next sum
  logic bit_en; // One pulse per serial bit
  logic [7:0] cnt_r; // Slot and bit position within the frame
  logic d1_r, d2_r, d3_r; // Fetch pipeline stages
  logic [7:0] fetch_addr;
  logic [2:0] fetch_stream;
  logic src_eff, oe_eff;
  logic [7:0] nxt_byte_r [0:7]; // Words for the coming channel
  logic [7:0] nxt_en_r;
  logic [7:0] shift_r [0:7]; // Words being shifted out
  logic [7:0] cur_en_r;

  // Two-flop synchronisers for all host and gate pins
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync1_r <= 18'h3ffff;
      sync2_r <= 18'h3ffff;
    end
    else
    begin
      sync1_r <= {HOST_ADDR, HOST_DATA_IN, HOST_CS_N, HOST_RD_N, HOST_WR_N, GLOBAL_OUTPUT_GATE};
      sync2_r <= sync1_r;
    end
  end

  assign {addr_s, din_s, cs_n_s, rd_n_s, wr_n_s, gate_s} = sync2_r;
  assign strobe = !cs_n_s && (!rd_n_s || !wr_n_s);
  assign split = ctrl_r[tsw_pkg::SPLIT_BIT];
  assign pe = ctrl_r[tsw_pkg::PE_BIT];
  assign ms = ctrl_r[tsw_pkg::MS_HI:tsw_pkg::MS_LO];
  // Stream number plus low address lines form the location
  assign host_mem_addr = {ctrl_r[tsw_pkg::STA_HI:0], addr_s[4:0]};

  // Control register, written at once in the idle state
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_r <= tsw_pkg::CTRL_RESET;
    end
    else if (state_r == tsw_pkg::ST_IDLE && strobe && !wr_n_s && !addr_s[tsw_pkg::REGION_BIT])
    begin
      ctrl_r <= din_s & tsw_pkg::CTRL_WMASK;
    end
  end

  // Host access sequencer
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r <= tsw_pkg::ST_IDLE;
      rd_cycle_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        tsw_pkg::ST_IDLE:
        begin
          rd_cycle_r <= !rd_n_s;
          if (strobe)
          begin
            state_r <= addr_s[tsw_pkg::REGION_BIT] ? tsw_pkg::ST_WAIT : tsw_pkg::ST_HOLD;
          end
        end
        // Two cycles for the memory write or the registered read
        tsw_pkg::ST_WAIT: state_r <= tsw_pkg::ST_DONE;
        tsw_pkg::ST_DONE: state_r <= tsw_pkg::ST_HOLD;
        default:
        begin
          // Wait for the host to end its strobe
          if (!strobe)
          begin
            state_r <= tsw_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Memory writes from the host, one cycle in the wait state; data memory is read-only
  assign low_we = (state_r == tsw_pkg::ST_WAIT) && !rd_cycle_r
    && (split || ms == tsw_pkg::MS_LOW);
  assign high_we = (state_r == tsw_pkg::ST_WAIT) && !rd_cycle_r
    && !split && ms == tsw_pkg::MS_HIGH;

  // Host read source; split mode reads data memory, code 00 reads zero
  assign mem_rd = (split || ms == tsw_pkg::MS_DATA) ? dm_a
    : (ms == tsw_pkg::MS_LOW) ? low_a
    : (ms == tsw_pkg::MS_HIGH) ? {5'h00, high_a} : 8'h00;

  // Read data capture; data memory is read-only, code 00 reads zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      host_rd_r <= 8'h00;
    end
    else if (state_r == tsw_pkg::ST_IDLE && strobe && !addr_s[tsw_pkg::REGION_BIT])
    begin
      host_rd_r <= ctrl_r & tsw_pkg::CTRL_WMASK;
    end
    else if (state_r == tsw_pkg::ST_DONE)
    begin
      host_rd_r <= mem_rd;
    end
  end

  assign HOST_READY = (state_r == tsw_pkg::ST_HOLD);
  assign HOST_DATA_OE = (state_r == tsw_pkg::ST_HOLD) && rd_cycle_r;
  assign HOST_DATA_OUT = host_rd_r;

  // Bit-rate divider; 10 MHz is no multiple of 2.048 MHz so a phase
  // accumulator spaces pulses 4 or 5 cycles apart with no long-term drift
  assign acc_sum = acc_r + tsw_pkg::ACC_STEP;
  assign bit_en = (acc_sum >= tsw_pkg::ACC_MOD);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      acc_r <= tsw_pkg::ACC_RESET;
      cnt_r <= tsw_pkg::CNT_RESET;
      d1_r <= 1'b0;
      d2_r <= 1'b0;
      d3_r <= 1'b0;
    end
    else
    begin
      acc_r <= bit_en ? acc_sum - tsw_pkg::ACC_MOD : acc_sum;
      if (bit_en)
      begin
        cnt_r <= cnt_r + 8'h01;
      end
      d1_r <= bit_en;
      d2_r <= d1_r;
      d3_r <= d2_r;
    end
  end

  // During bit k of a slot, fetch stream k of the following channel
  assign fetch_stream = cnt_r[2:0];
  assign fetch_addr = {fetch_stream, 5'(cnt_r[7:3] + 5'h01)};
  assign src_eff = high_b[tsw_pkg::HW_SRC] || pe;
  assign oe_eff = high_b[tsw_pkg::HW_OE] || pe;

  // Collect next-channel words and drive the control bitstream
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      nxt_en_r <= 8'h00;
      CONTROL_BITSTREAM_OUT <= 1'b0;
      for (int s = 0; s < 8; s++)
        nxt_byte_r[s] <= 8'h00;
    end
    else if (d3_r)
    begin
      nxt_byte_r[fetch_stream] <= src_eff ? low_b : dm_b;
      nxt_en_r[fetch_stream] <= oe_eff;
      CONTROL_BITSTREAM_OUT <= high_b[tsw_pkg::HW_CCO];
    end
  end

  // Shift the words out msb first, reloading at each slot start
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cur_en_r <= 8'h00;
      SERIAL_OUTPUT_STREAMS <= 8'h00;
      for (int s = 0; s < 8; s++)
        shift_r[s] <= 8'h00;
    end
    else if (d3_r)
    begin
      for (int s = 0; s < 8; s++)
      begin
        if (cnt_r[2:0] == 3'h0)
        begin
          SERIAL_OUTPUT_STREAMS[s] <= nxt_byte_r[s][7];
          shift_r[s] <= {nxt_byte_r[s][6:0], 1'b0};
          cur_en_r[s] <= nxt_en_r[s];
        end
        else
        begin
          SERIAL_OUTPUT_STREAMS[s] <= shift_r[s][7];
          shift_r[s] <= {shift_r[s][6:0], 1'b0};
        end
      end
    end
  end

  // Gate pin overrides every enable; new enables land with the slot's first bit
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SERIAL_OUTPUT_OE <= 8'h00;
    end
    else
    begin
      SERIAL_OUTPUT_OE <= ((d3_r && cnt_r[2:0] == 3'h0) ? nxt_en_r : cur_en_r)
        & {8{gate_s}};
    end
  end

  // Data memory: filled by the framer, read by host and switch
  tsw_mem #(.W(8)) u_data_mem (
    .clk(CLK), .reset_n(RESET_N),
    .wr_en(DM_WR_EN), .wr_addr(DM_WR_ADDR), .wr_data(DM_WR_DATA),
    .ra_addr(host_mem_addr), .ra_data(dm_a),
    .rb_addr(low_b), .rb_data(dm_b)
  );

  // Low words: literal data or source address
  tsw_mem #(.W(8)) u_low_mem (
    .clk(CLK), .reset_n(RESET_N),
    .wr_en(low_we), .wr_addr(host_mem_addr), .wr_data(din_s),
    .ra_addr(host_mem_addr), .ra_data(low_a),
    .rb_addr(fetch_addr), .rb_data(low_b)
  );

  // High words: only source, bitstream and enable bits exist
  tsw_mem #(.W(tsw_pkg::HW_W)) u_high_mem (
    .clk(CLK), .reset_n(RESET_N),
    .wr_en(high_we), .wr_addr(host_mem_addr), .wr_data(din_s[tsw_pkg::HW_W-1:0]),
    .ra_addr(host_mem_addr), .ra_data(high_a),
    .rb_addr(fetch_addr), .rb_data(high_b)
  );
endmodule

// >>> tsw_switch_ctrl_assertions.sv
// Port checks for the slot switch control block
`timescale 1ns/1ps
module tsw_switch_ctrl_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Host port
  input wire logic [5:0] HOST_ADDR,
  input wire logic HOST_CS_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE,
  input wire logic HOST_READY,
  // Serial side
  input wire logic GLOBAL_OUTPUT_GATE,
  input wire logic [7:0] SERIAL_OUTPUT_OE,
  input wire logic CONTROL_BITSTREAM_OUT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // Quiet outputs right after reset
  reset_quiet_a: assert property ($rose(RESET_N) |-> !SERIAL_OUTPUT_OE && !HOST_READY)
    else $error("outputs active after reset");
  // Gate low floats every stream
  gate_float_a: assert property (!GLOBAL_OUTPUT_GATE [*4] |-> !SERIAL_OUTPUT_OE)
    else $error("stream driven with gate low");
  // Control write answers fast
  fast_ctrl_a: assert property ($fell(HOST_CS_N) && !HOST_WR_N && !HOST_ADDR[5] |-> ##3 HOST_READY)
    else $error("slow control write");
  // Channel access takes two cycles more
  slow_chan_a: assert property ($fell(HOST_CS_N) && HOST_ADDR[5] |-> !HOST_READY [*5] ##1 HOST_READY)
    else $error("channel access timing");
  // Ready only after a strobe
  ready_cause_a: assert property ($rose(HOST_READY) |-> $past(!HOST_CS_N, 2))
    else $error("ready without strobe");
  // Ready drops once strobe gone
  ready_drop_a: assert property (HOST_CS_N [*4] |-> !HOST_READY)
    else $error("ready stuck");
  // Read data driven only when complete
  data_drive_a: assert property (HOST_DATA_OE |-> HOST_READY)
    else $error("data driven early");
  // Unused control bit reads zero
  ctrl_unused_a: assert property (HOST_DATA_OE && !HOST_ADDR[5] |-> !HOST_DATA_OUT[5])
    else $error("control bit 5 set");
  // Bitstream holds a whole bit time
  cco_hold_a: assert property ($changed(CONTROL_BITSTREAM_OUT) |=> $stable(CONTROL_BITSTREAM_OUT) [*3])
    else $error("bitstream bit too short");
  // Main scenarios
  cover property (HOST_READY && !HOST_ADDR[5] && !HOST_WR_N);
  cover property (HOST_DATA_OE && HOST_ADDR[5]);
  cover property ($rose(CONTROL_BITSTREAM_OUT));
endmodule

bind tsw_switch_ctrl tsw_switch_ctrl_assertions i_chk (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .HOST_ADDR(HOST_ADDR),
  .HOST_CS_N(HOST_CS_N),
  .HOST_WR_N(HOST_WR_N),
  .HOST_DATA_OUT(HOST_DATA_OUT),
  .HOST_DATA_OE(HOST_DATA_OE),
  .HOST_READY(HOST_READY),
  .GLOBAL_OUTPUT_GATE(GLOBAL_OUTPUT_GATE),
  .SERIAL_OUTPUT_OE(SERIAL_OUTPUT_OE),
  .CONTROL_BITSTREAM_OUT(CONTROL_BITSTREAM_OUT)
);

// >>> tsw_host.sv
// Host processor model on the parallel register port
`timescale 1ns/1ps
module tsw_host (
  // Clock
  input wire logic clk,
  // Port pins
  output logic [5:0] addr,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] dq,
  input wire logic [7:0] bus,
  input wire logic ready
);
  // Strobes idle at start
  initial
  begin
    addr = 6'h00;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dq = 8'h55;
  end
  // Hold request until ready, then release and wait for idle
  task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok, output int n);
    @(negedge clk);
    addr = a;
    dq = r ? ~dq : d;
    cs_n = 1'b0;
    rd_n = !r;
    wr_n = r;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ready !== 1'b1 && n < 20);
    q = bus;
    ok = ready === 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dq = ~dq;  // Undriven line must not look stable
    for (int k = 0; k < 20 && ready !== 1'b0; k++)
      @(posedge clk);
    ok = ok && ready === 1'b0;
    @(posedge clk);  // Idle gap before the next access
  endtask
endmodule

// >>> tsw_switch_ctrl_tb.sv
// Self-checking bench for the slot switch control block
`timescale 1ns/1ps
module tsw_switch_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gate = 1'b0;  // Low until high words are set
  logic dm_en = 1'b0;
  logic [7:0] dm_a = 8'h00;
  logic [7:0] dm_d = 8'h00;
  logic [5:0] addr;
  logic cs_n, rd_n, wr_n, rdy, doe, control_bitstream_out, ok, pv;
  logic [7:0] dq, dout, so, soe, q;
  logic [7:0] hw [8] = '{8'h07, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] lw [8] = '{8'hff, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  wire [7:0] bus = doe ? dout : dq;
  int n_errors = 0;
  int num_checks = 0;
  int cyc, n, bad, rises;
  always #50 clk = ~clk;
  tsw_switch_ctrl i_tsw_switch_ctrl (.CLK(clk), .RESET_N(rst_n), .HOST_ADDR(addr),
    .HOST_CS_N(cs_n), .HOST_RD_N(rd_n), .HOST_WR_N(wr_n), .HOST_DATA_IN(bus),
    .HOST_DATA_OUT(dout), .HOST_DATA_OE(doe), .HOST_READY(rdy), .DM_WR_EN(dm_en),
    .DM_WR_ADDR(dm_a), .DM_WR_DATA(dm_d), .GLOBAL_OUTPUT_GATE(gate),
    .SERIAL_OUTPUT_STREAMS(so), .SERIAL_OUTPUT_OE(soe), .CONTROL_BITSTREAM_OUT(control_bitstream_out));
  tsw_host i_tsw_host (.clk(clk), .addr(addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .dq(dq), .bus(bus), .ready(rdy));
  task test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input logic r, input logic [5:0] a, input logic [7:0] d);
    i_tsw_host.acc(r, a, d, q, ok, cyc);
    if (!ok)
    begin
      n_errors++;
      $display("[ERR] %0t host access hung", $time);
      test_done();
    end
  endtask
  task dm(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    dm_en = 1'b1;
    dm_a = a;
    dm_d = d;
    @(negedge clk);
    dm_en = 1'b0;
  endtask
  // Settle one frame, then watch one full frame
  task watch(input logic [7:0] eoe, input logic [7:0] m, input logic [7:0] ev);
    repeat (1300) @(negedge clk);
    bad = 0;
    rises = 0;
    pv = control_bitstream_out;
    repeat (1250)
    begin
      @(negedge clk);
      bad += (soe !== eoe || (so & m) !== ev);
      rises += (control_bitstream_out === 1'b1 && pv === 1'b0);
      pv = control_bitstream_out;
    end
    chk({7'h00, bad != 0}, 8'h00);
    chk(8'(rises), 8'h20);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk(soe, 8'h00);
    acc(1, 6'h00, 8'h00);
    chk(q, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      acc(0, 6'(i), 8'(i * 37) | 8'h08);
      acc(1, 6'(31 - i), 8'h00);
      chk(q, (8'(i * 37) | 8'h08) & 8'hdf);
    end
    acc(0, 6'h1f, 8'h18);
    n = cyc;
    acc(0, 6'h3f, 8'hff);
    chk(8'(cyc), 8'(n + 2));
    acc(1, 6'h3f, 8'h00);
    chk(q, 8'h07);
    dm(8'h07, 8'hff);
    dm(8'h89, 8'h3c);
    for (int s = 0; s < 8; s++)
    begin
      acc(0, 6'h00, {3'h0, tsw_pkg::MS_HIGH, 3'(s)});
      for (int c = 0; c < 32; c++)
        acc(0, {1'b1, 5'(c)}, hw[s]);
      acc(0, 6'h00, {3'h0, tsw_pkg::MS_LOW, 3'(s)});
      for (int c = 0; c < 32; c++)
        acc(0, {1'b1, 5'(c)}, lw[s]);
    end
    acc(0, 6'h00, 8'h12);
    acc(1, 6'h22, 8'h00);
    chk(q, 8'h07);
    acc(0, 6'h00, 8'h08);
    acc(0, 6'h27, 8'h00);
    acc(1, 6'h27, 8'h00);
    chk(q, 8'hff);
    acc(0, 6'h00, 8'h0c);  // Data memory of stream 4, host writes there are dropped
    acc(0, 6'h29, 8'h77);
    acc(1, 6'h29, 8'h00);
    chk(q, 8'h3c);
    acc(0, 6'h00, 8'h9c);
    acc(0, 6'h29, 8'h5a);
    acc(1, 6'h29, 8'h00);
    chk(q, 8'h3c);
    acc(0, 6'h00, 8'h14);
    acc(1, 6'h29, 8'h00);
    chk(q, 8'h5a);
    @(negedge clk);
    gate = 1'b1;
    watch(8'h07, 8'h07, 8'h05);
    acc(0, 6'h00, 8'h58);
    watch(8'hff, 8'h0b, 8'h01);
    gate = 1'b0;
    repeat (5) @(negedge clk);
    chk(soe, 8'h00);
    rst_n = 1'b0;
    @(negedge clk);
    chk(soe, 8'h00);
    rst_n = 1'b1;
    acc(1, 6'h00, 8'h00);
    chk(q, 8'h00);
    test_done();
  end
endmodule
